// ===== lcg_gate.sv
/*
  One data gate: ORs the selected true and inverted copies of the four
  data inputs, then applies the gate polarity. Purely combinational;
  the caller registers the result.
*/
`timescale 1ns/1ps
`default_nettype none
module lcg_gate #(
  parameter int IN_N = lcg_pkg::IN_N
) (
  // Selection and data
  input wire logic [2*IN_N-1:0] sel,
  input wire logic [IN_N-1:0] data_in,
  input wire logic invert,
  // Gate result
  output logic gate_out
);
  logic [IN_N-1:0] term;

  genvar k;
  generate
    for (k = 0; k < IN_N; k++) begin : g_term
      assign term[k] = (sel[2*k+lcg_pkg::SEL_TRUE_POS] & data_in[k]) |
                       (sel[2*k+lcg_pkg::SEL_INV_POS] & ~data_in[k]);
    end
  endgenerate

  // Zero when nothing selected, then optional inversion
  assign gate_out = (|term) ^ invert;
endmodule
`default_nettype wire

// ===== lcg_monitor.sv
/* Port-level checker for lcg_top: APB answer timing and read data shape.
   Assumes it is bound into lcg_top and that por_n stays high after start. */
`timescale 1ns/1ps
`default_nettype none
module lcg_monitor (
  // Clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Cell side
  input wire logic cell_data_in1,
  input wire logic cell_data_in2,
  input wire logic cell_data_in3,
  input wire logic cell_data_in4,
  input wire logic gate1_out,
  input wire logic cell_out_invert
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !por_n);
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  chk_upper_bits_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("prdata upper bits set");
  chk_mirror_high_zero: assert property (
    pready && !pwrite && paddr == lcg_pkg::OFF_OUT_MIRROR |-> prdata[7:4] == 4'h0 && !pslverr)
    else $error("mirror high bits set");
  chk_invert_follows: assert property (
    psel && penable && pready && pwrite && pstrb[0] && paddr == lcg_pkg::OFF_POLARITY
    |-> ##2 cell_out_invert == $past(pwdata[7], 2))
    else $error("cell_out_invert not updated");
  chk_unmapped_err: assert property (pready && paddr > lcg_pkg::OFF_OUT_MIRROR |-> pslverr)
    else $error("unmapped access without error");
  chk_gate_steady: assert property (
    ($stable({cell_data_in1, cell_data_in2, cell_data_in3, cell_data_in4}) && !psel)[*6]
    |-> $stable(gate1_out))
    else $error("gate output moved with steady inputs");
endmodule
`default_nettype wire

// ===== lcg_pkg.sv
/*
  Package for the logic cell gate select block: register offsets, field
  layout, reset values and the APB address decode state.
  Assumes a 32-bit APB slave with byte addresses, one register per word.
*/
package lcg_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int REG_W = 8;
  localparam int IN_N = 4;
  localparam int GATE_N = 3;
  localparam int CELL_N = 4;

  localparam logic [11:0] OFF_GATE1_SEL = 12'h000;
  localparam logic [11:0] OFF_GATE2_SEL = 12'h004;
  localparam logic [11:0] OFF_GATE3_SEL = 12'h008;
  localparam logic [11:0] OFF_POLARITY = 12'h00C;
  localparam logic [11:0] OFF_OUT_MIRROR = 12'h010;

  // Field positions within a select register: input k uses bits 2k+1 (true), 2k (inverted)
  localparam int SEL_TRUE_POS = 1;
  localparam int SEL_INV_POS = 0;
  // Polarity register fields
  localparam int POL_CELL_POS = 7;
  localparam int POL_GATE1_POS = 1;

  // Cold-reset value of the select registers (unknown by spec, zero here)
  localparam logic [7:0] SEL_COLD_RST = 8'h00;
  localparam logic [7:0] POL_COLD_RST = 8'h00;
  localparam logic [7:0] POL_MASK = 8'h8F;
  localparam logic [7:0] MIRROR_RST = 8'h00;
  localparam logic [3:0] MIRROR_MASK = 4'hF;

  typedef enum logic [2:0] {
    REG_G1, REG_G2, REG_G3, REG_POL, REG_MIRROR, REG_NONE
  } lcg_reg_sel_t;
endpackage

// ===== lcg_sel_reg.sv
/*
  One 8-bit read/write gate select register.
  Cleared only by the cold reset; the warm reset is not wired here, so
  ordinary resets leave the contents as they were.
*/
`timescale 1ns/1ps
`default_nettype none
module lcg_sel_reg #(
  parameter logic [7:0] RST_VAL = lcg_pkg::SEL_COLD_RST
) (
  // Clock and cold reset
  input wire logic pclk,
  input wire logic por_n,
  // Write port
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // Stored value
  output logic [7:0] value
);
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      value <= RST_VAL;
    end else if (wr_en) begin
      value <= wr_data;
    end
  end
endmodule
`default_nettype wire

// ===== lcg_top.sv
/*
  Gate input selection for gates 1..3 of a configurable logic cell, with
  a polarity register and a read-only mirror of the four cell outputs,
  reached over APB.
  Assumes data inputs and cell outputs may come from other clock domains
  and are synchronised here; por_n is the power-on/brown-out reset,
  presetn the ordinary reset.
*/
// Overview of operation
// - Gate 1 select bit 7 gates true data 4, bit 6 inverted data 4.
// - Gate 1 select bits 5 and 4 gate true and inverted data 3.
// - Gate 1 select bits 3 and 2 gate true and inverted data 2.
// - Gate 1 select bits 1 and 0 gate true and inverted data 1.
// - Gate 2 select bits 7 and 6 gate true and inverted data 4.
// - Gate 2 select bits 5 and 4 gate true and inverted data 3.
// - Gate 2 select bits 3 and 2 gate true and inverted data 2.
// - Gate 2 select bits 1 and 0 gate true and inverted data 1.
// - Gate 3 select bits 7 and 6 gate true and inverted data 4.
// - Gate 3 select bits 5 and 4 gate true and inverted data 3.
// - Gate 3 select bits 3 and 2 gate true and inverted data 2.
// - Gate 3 select bits 1 and 0 gate true and inverted data 1.
// - Select registers fully read/write; only cold reset touches them.
// - Mirror register bits 3..0 copy cell outputs 4..1; resets to zero.
// - Mirror register bits 7..4 always read zero.
// - Polarity bits 3..1 invert gate outputs 3..1; top bit inverts the cell output.
`timescale 1ns/1ps
`default_nettype none
module lcg_top (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Cold reset
  input wire logic por_n,
  // Cell data inputs
  input wire logic cell_data_in1,
  input wire logic cell_data_in2,
  input wire logic cell_data_in3,
  input wire logic cell_data_in4,
  // Cell outputs from the cell logic
  input wire logic cell1_output,
  input wire logic cell2_output,
  input wire logic cell3_output,
  input wire logic cell4_output,
  // Gate results after polarity, and the cell output invert bit
  output logic gate1_out,
  output logic gate2_out,
  output logic gate3_out,
  output logic cell_out_invert
);
  function automatic lcg_pkg::lcg_reg_sel_t decode(input logic [11:0] addr);
    case (addr)
      lcg_pkg::OFF_GATE1_SEL: decode = lcg_pkg::REG_G1;
      lcg_pkg::OFF_GATE2_SEL: decode = lcg_pkg::REG_G2;
      lcg_pkg::OFF_GATE3_SEL: decode = lcg_pkg::REG_G3;
      lcg_pkg::OFF_POLARITY: decode = lcg_pkg::REG_POL;
      lcg_pkg::OFF_OUT_MIRROR: decode = lcg_pkg::REG_MIRROR;
      default: decode = lcg_pkg::REG_NONE;
    endcase
  endfunction

  lcg_pkg::lcg_reg_sel_t reg_hit;
  logic access;
  logic wr_ok;
  logic [2:0] sel_wr;
  logic [7:0] sel_val [3];
  logic [7:0] pol_reg;
  logic [3:0] data_s1_reg;
  logic [3:0] data_s2_reg;
  logic [3:0] cell_s1_reg;
  logic [3:0] cell_s2_reg;
  logic [3:0] mirror_reg;
  logic [2:0] gate_comb;

  assign reg_hit = decode(paddr);
  assign access = psel & penable;
  // Byte lane 0 carries the whole 8-bit register
  assign wr_ok = access & pwrite & pstrb[0];

  assign sel_wr[0] = wr_ok & (reg_hit == lcg_pkg::REG_G1);
  assign sel_wr[1] = wr_ok & (reg_hit == lcg_pkg::REG_G2);
  assign sel_wr[2] = wr_ok & (reg_hit == lcg_pkg::REG_G3);

  genvar g;
  generate
    for (g = 0; g < lcg_pkg::GATE_N; g++) begin : g_gate
      lcg_sel_reg #(
        .RST_VAL(lcg_pkg::SEL_COLD_RST)
      ) u_sel (
        .pclk(pclk),
        .por_n(por_n),
        .wr_en(sel_wr[g]),
        .wr_data(pwdata[7:0]),
        .value(sel_val[g])
      );
      // Bit pairs 7/6, 5/4, 3/2, 1/0 map to data 4, 3, 2, 1
      lcg_gate #(
        .IN_N(lcg_pkg::IN_N)
      ) u_gate (
        .sel(sel_val[g]),
        .data_in(data_s2_reg),
        .invert(pol_reg[lcg_pkg::POL_GATE1_POS+g]),
        .gate_out(gate_comb[g])
      );
    end
  endgenerate

  // Input synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_s1_reg <= 4'h0;
      data_s2_reg <= 4'h0;
    end else begin
      data_s1_reg <= {cell_data_in4, cell_data_in3, cell_data_in2, cell_data_in1};
      data_s2_reg <= data_s1_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_s1_reg <= 4'h0;
      cell_s2_reg <= 4'h0;
    end else begin
      cell_s1_reg <= {cell4_output, cell3_output, cell2_output, cell1_output};
      cell_s2_reg <= cell_s1_reg;
    end
  end

  // Mirror of cell outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mirror_reg <= lcg_pkg::MIRROR_RST[3:0];
    end else begin
      mirror_reg <= cell_s2_reg & lcg_pkg::MIRROR_MASK;
    end
  end

  // Polarity register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_reg <= lcg_pkg::POL_COLD_RST;
    end else if (wr_ok && reg_hit == lcg_pkg::REG_POL) begin
      pol_reg <= pwdata[7:0] & lcg_pkg::POL_MASK;
    end
  end

  // Registered gate outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate1_out <= 1'b0;
      gate2_out <= 1'b0;
      gate3_out <= 1'b0;
      cell_out_invert <= 1'b0;
    end else begin
      gate1_out <= gate_comb[0];
      gate2_out <= gate_comb[1];
      gate3_out <= gate_comb[2];
      cell_out_invert <= pol_reg[lcg_pkg::POL_CELL_POS];
    end
  end

  // APB answer: no wait states, data registered at the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (decode(paddr) == lcg_pkg::REG_NONE);
      if (psel && !penable && !pwrite) begin
        case (reg_hit)
          lcg_pkg::REG_G1: prdata <= {24'h000000, sel_val[0]};
          lcg_pkg::REG_G2: prdata <= {24'h000000, sel_val[1]};
          lcg_pkg::REG_G3: prdata <= {24'h000000, sel_val[2]};
          lcg_pkg::REG_POL: prdata <= {24'h000000, pol_reg};
          lcg_pkg::REG_MIRROR: prdata <= {28'h0000000, mirror_reg};
          default: prdata <= 32'h0000_0000;
        endcase
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end
endmodule
`default_nettype wire

// ===== test_logic_cell_gate_select.sv
/* Self-checking bench for lcg_top: register access, gate results, mirror.
   Assumes lcg_monitor is compiled beside it and bound below. */
`timescale 1ns/1ps
`default_nettype none
module test_logic_cell_gate_select;
  logic pclk = 1'b0, presetn = 1'b0, por_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic cell_data_in1 = 1'b0, cell_data_in2 = 1'b0, cell_data_in3 = 1'b0, cell_data_in4 = 1'b0;
  logic cell1_output = 1'b0, cell2_output = 1'b0, cell3_output = 1'b0, cell4_output = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, gate1_out, gate2_out, gate3_out, cell_out_invert, er;
  logic [7:0] s [3];
  logic [7:0] pol;
  logic [3:0] d, c;
  int n_fail = 0, num_checks = 0, cyc = 0;
  lcg_top dut_u (.*);
  always #10 pclk = ~pclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic give_verdict;
    if (n_fail == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic logic gexp(logic [7:0] sl, logic [3:0] dd, logic p);
    gexp = |(sl & {dd[3], ~dd[3], dd[2], ~dd[2], dd[1], ~dd[1], dd[0], ~dd[0]}) ^ p;
  endfunction
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(32'hda29319e));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    apb(1'b0, lcg_pkg::OFF_OUT_MIRROR, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 40; i++) begin
      for (int g = 0; g < 3; g++) begin
        s[g] = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
        apb(1'b1, lcg_pkg::OFF_GATE1_SEL + 12'(4 * g), {24'h0, s[g]});
      end
      pol = 8'($urandom) & lcg_pkg::POL_MASK;
      apb(1'b1, lcg_pkg::OFF_POLARITY, {24'h0, pol});
      {d, c} = 8'($urandom);
      cell_data_in1 <= d[0];
      cell_data_in2 <= d[1];
      cell_data_in3 <= d[2];
      cell_data_in4 <= d[3];
      cell1_output <= c[0];
      cell2_output <= c[1];
      cell3_output <= c[2];
      cell4_output <= c[3];
      repeat (7) @(posedge pclk);
      chk(gate1_out, gexp(s[0], d, pol[1]));
      chk(gate2_out, gexp(s[1], d, pol[2]));
      chk(gate3_out, gexp(s[2], d, pol[3]));
      chk(cell_out_invert, pol[7]);
      for (int g = 0; g < 3; g++) begin
        apb(1'b0, lcg_pkg::OFF_GATE1_SEL + 12'(4 * g), 32'h0);
        chk(rd, {24'h0, s[g]});
      end
      apb(1'b0, lcg_pkg::OFF_OUT_MIRROR, 32'h0);
      chk(rd, {28'h0, c});
    end
    apb(1'b0, 12'h014, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int g = 0; g < 3; g++) begin
      apb(1'b0, lcg_pkg::OFF_GATE1_SEL + 12'(4 * g), 32'h0);
      chk(rd, {24'h0, s[g]});
    end
    give_verdict();
  end
endmodule
bind lcg_top lcg_monitor mon_u (.*);
`default_nettype wire
